// ---- verilog/ccu_consts.vh ----
/*
 * Constants for the dual capture/compare array: register word indices,
 * field positions, mode codes and reset values.
 * Assumes inclusion by the array module only; definitions only.
 */
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH

// ************************************************************
// Register word indices (byte address = index * 4)
// ************************************************************
`define CCU_IDX_TCTL 8'h00
`define CCU_IDX_TVAL 8'h04
`define CCU_IDX_TRLD 8'h08
`define CCU_IDX_CCTL 8'h20
`define CCU_IDX_CVAL 8'h40

// ************************************************************
// Timer control fields
// ************************************************************
`define CCU_TCTL_RUN 0
`define CCU_TCTL_SRC_LO 1
`define CCU_TCTL_PSC_LO 3
`define CCU_TCTL_RST 6'h00
`define CCU_SRC_PSC 2'h0
`define CCU_SRC_GT6 2'h1
`define CCU_SRC_EXT 2'h2

// ************************************************************
// Channel control fields and modes
// ************************************************************
`define CCU_CCTL_TSEL 3
`define CCU_CCTL_EDGE_LO 4
`define CCU_CCTL_RST 6'h00
`define CCU_MODE_OFF 3'h0
`define CCU_MODE_CAP 3'h1
`define CCU_MODE_DBL 3'h2
`define CCU_MODE_CMP0 3'h4
`define CCU_MODE_CMP1 3'h5
`define CCU_MODE_CMP2 3'h6
`define CCU_MODE_CMP3 3'h7
`define CCU_EDGE_RISE 2'h1
`define CCU_EDGE_FALL 2'h2
`define CCU_EDGE_BOTH 2'h3

// ************************************************************
// Timing
// ************************************************************
`define CCU_DIV_MIN_LOG2 3
`define CCU_VAL_RST 16'h0000

`endif

// ---- verilog/ccu_array.v ----
/*
 * Dual 16-channel capture/compare array with four 16-bit reloadable
 * time-base timers, reached over a classic Wishbone slave.
 * Assumes one clock I_MCLK; capture pins and external count pins are
 * asynchronous; I_GT6_OVF comes from logic on the same clock.
 */
// The implementer's own choices: the register offsets and the Wishbone register port.
`include "ccu_consts.vh"

// What this block does
// - Two units, sixteen channels each, 32 total
// - Two reloadable 16-bit timers per unit
// - Timers clocked by prescaler or timer six
// - First timer per unit takes external count
// - Channel picks timer and capture or compare
// - One pin per channel, input or output
// - Capture copies assigned timer on pin event
// - Each capture raises channel interrupt request
// - Capture edge: rising, falling or both
// - Compare modes match register against timer
// - Mode 0: interrupt each match, pin untouched
// - Mode 1: pin toggles every match
// - Mode 2: one interrupt per period
// - Mode 3: set once, clear on overflow
// - Double mode: in channels 0-7 of a unit, own and partner registers toggle one pin
// - Prescaler codes divide by 8 to 1024
// - Overflow reloads; zero gives full period
// - Unit two channels 8-11 input only
// - Shared count signal keeps timers in lockstep
// - Fastest prescaler rate: clock divided by eight
module ccu_array #(
    parameter CH_N = 32,
    parameter [31:0] OUT_OK = 32'hf0ff_ffff
) (
    input wire I_MCLK,
    input wire I_RST,
    input wire I_WB_CYC,
    input wire I_WB_STB,
    input wire I_WB_WE,
    input wire [9:0] I_WB_ADR,
    input wire [31:0] I_WB_DAT,
    input wire [3:0] I_WB_SEL,
    output reg [31:0] O_WB_DAT,
    output reg O_WB_ACK,
    input wire I_GT6_OVF,
    input wire [1:0] I_EXT_CNT,
    input wire [31:0] I_CC_PIN,
    output wire [31:0] O_CC_PIN,
    output wire [31:0] O_CC_OE,
    output wire [31:0] O_CC_IRQ
);

// ************************************************************
// Bus slave
// ************************************************************
wire bus_req; // Request present and not yet answered
wire bus_wr; // Write taking effect at this edge
wire [7:0] bus_idx; // Word index of the access
reg [31:0] rd_next; // Read data for the answer

assign bus_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
assign bus_wr = bus_req & I_WB_WE;
assign bus_idx = I_WB_ADR[9:2];

// Lane merge for 16-bit registers in the low half
function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = dat[15:8];
        end
    end
endfunction

// Answer one cycle after the request; ack drops the cycle after
always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
        O_WB_ACK <= 1'b0;
        O_WB_DAT <= 32'h0000_0000;
    end else begin
        O_WB_ACK <= bus_req;
        if (bus_req && !I_WB_WE) begin
            O_WB_DAT <= rd_next;
        end
    end
end

// ************************************************************
// Input synchronisers
// ************************************************************
reg [33:0] sync1_reg; // First stage, read only by second stage
reg [33:0] sync2_reg; // Stable copy
reg [33:0] sync3_reg; // Delayed copy for edges
wire [31:0] pin_rise; // Rising edges of capture pins
wire [31:0] pin_fall; // Falling edges of capture pins
wire [1:0] ext_rise; // External count events

// Two flip-flops before any edge logic reads a pin
always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
        sync1_reg <= 34'h0_0000_0000;
        sync2_reg <= 34'h0_0000_0000;
        sync3_reg <= 34'h0_0000_0000;
    end else begin
        sync1_reg <= {I_EXT_CNT, I_CC_PIN};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end
end

assign pin_rise = sync2_reg[31:0] & ~sync3_reg[31:0];
assign pin_fall = ~sync2_reg[31:0] & sync3_reg[31:0];
// One count pin per unit; both units share identical logic, so a
// common signal on both pins steps the two timers on the same edge
assign ext_rise = sync2_reg[33:32] & ~sync3_reg[33:32];

// ************************************************************
// Prescaler
// ************************************************************
reg [9:0] psc_reg; // Free running divider shared by all timers

// One counter feeds every timer; a code picks its low bits
always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
        psc_reg <= 10'h000;
    end else begin
        psc_reg <= psc_reg + 10'h001;
    end
end

// ************************************************************
// Time-base timers
// ************************************************************
wire [63:0] tmr_val; // Current counts, timer t at [16t+15:16t]
wire [63:0] tmr_rld; // Reload values
wire [23:0] tmr_ctl; // Control fields
wire [3:0] tmr_step; // Count changed last edge
wire [3:0] tmr_ovf; // Count overflowed last edge

genvar t;
generate
for (t = 0; t < 4; t = t + 1) begin : g_tmr
    reg [15:0] cnt_reg; // Count
    reg [15:0] rld_reg; // Reload value
    reg [5:0] ctl_reg; // Run, source and prescaler code
    reg step_reg; // Count moved
    reg ovf_reg; // Count wrapped
    reg tick; // Count enable this cycle
    reg [9:0] psc_mask; // Low divider bits that must be zero
    wire [2:0] psc_sel;
    wire [1:0] src;

    assign psc_sel = ctl_reg[`CCU_TCTL_PSC_LO +: 3];
    assign src = ctl_reg[`CCU_TCTL_SRC_LO +: 2];

    // Pick the count source; only timer a of a unit has a pin
    always @* begin
        psc_mask = (10'h008 << psc_sel) - 10'h001;
        tick = 1'b0;
        case (src)
            `CCU_SRC_PSC: begin
                tick = (psc_reg & psc_mask) == 10'h000;
            end
            `CCU_SRC_GT6: begin
                tick = I_GT6_OVF;
            end
            `CCU_SRC_EXT: begin
                tick = (t % 2 == 0) ? ext_rise[t / 2] : 1'b0;
            end
            default: begin
                tick = 1'b0;
            end
        endcase
        tick = tick & ctl_reg[`CCU_TCTL_RUN];
    end

    // Count up, reload on wrap; software write wins over counting
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            cnt_reg <= `CCU_VAL_RST;
            rld_reg <= `CCU_VAL_RST;
            ctl_reg <= `CCU_TCTL_RST;
            step_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            step_reg <= 1'b0;
            ovf_reg <= 1'b0;
            if (bus_wr && bus_idx == `CCU_IDX_TCTL + t) begin
                if (I_WB_SEL[0]) begin
                    ctl_reg <= I_WB_DAT[5:0];
                end
            end
            if (bus_wr && bus_idx == `CCU_IDX_TRLD + t) begin
                rld_reg <= merge16(rld_reg, I_WB_DAT, I_WB_SEL);
            end
            if (bus_wr && bus_idx == `CCU_IDX_TVAL + t) begin
                cnt_reg <= merge16(cnt_reg, I_WB_DAT, I_WB_SEL);
            end else if (tick) begin
                step_reg <= 1'b1;
                if (cnt_reg == 16'hffff) begin
                    cnt_reg <= rld_reg;
                    ovf_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end
        end
    end

    assign tmr_val[16 * t +: 16] = cnt_reg;
    assign tmr_rld[16 * t +: 16] = rld_reg;
    assign tmr_ctl[6 * t +: 6] = ctl_reg;
    assign tmr_step[t] = step_reg;
    assign tmr_ovf[t] = ovf_reg;
end
endgenerate

// ************************************************************
// Channels
// ************************************************************
wire [511:0] ch_val; // Channel registers, 16 bits each
wire [255:0] ch_ctl; // Channel control plus state, 8 bits each

genvar c;
generate
for (c = 0; c < CH_N; c = c + 1) begin : g_ch
    localparam U = c / 16; // Unit of this channel
    localparam L = c % 16; // Position within unit
    localparam P = (L < 8) ? c + 8 : c; // Double mode partner
    reg [15:0] val_reg; // Capture/compare register
    reg [5:0] ctl_reg; // Mode, timer select, edge select
    reg done_reg; // Match already acted on this period
    reg pin_reg; // Output pin level
    reg oe_reg; // Output enable
    reg irq_reg; // Interrupt request pulse
    wire [2:0] mode;
    wire [1:0] edge_sel;
    wire [1:0] tidx;
    wire [15:0] tv;
    wire step;
    wire ovf;
    wire hit;
    wire cap_ev;
    wire dbl_hit;

    assign mode = ctl_reg[2:0];
    assign edge_sel = ctl_reg[`CCU_CCTL_EDGE_LO +: 2];
    // Each channel follows timer a or b of its own unit
    assign tidx = {U[0], ctl_reg[`CCU_CCTL_TSEL]};
    assign tv = tmr_val[16 * tidx +: 16];
    assign step = tmr_step[tidx];
    assign ovf = tmr_ovf[tidx];
    // Compare only just after the count moves, so a slow timer
    // that rests on a value gives one match, not many
    assign hit = step && tv == val_reg && mode[2];
    assign dbl_hit = step && mode == `CCU_MODE_DBL && (tv == val_reg ||
        (L < 8 && tv == ch_val[16 * P +: 16]));
    assign cap_ev = mode == `CCU_MODE_CAP &&
        ((edge_sel[0] && pin_rise[c]) ||
         (edge_sel[1] && pin_fall[c]));

    // Register, pin and request update per channel
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            val_reg <= `CCU_VAL_RST;
            ctl_reg <= `CCU_CCTL_RST;
            done_reg <= 1'b0;
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            if (bus_wr && bus_idx == `CCU_IDX_CCTL + c) begin
                if (I_WB_SEL[0]) begin
                    ctl_reg <= I_WB_DAT[5:0];
                end
            end
            // Capture beats a software write in the same cycle
            if (cap_ev) begin
                val_reg <= tv;
                irq_reg <= 1'b1;
            end else if (bus_wr && bus_idx == `CCU_IDX_CVAL + c) begin
                val_reg <= merge16(val_reg, I_WB_DAT, I_WB_SEL);
            end
            // Unit two channels 8-11 never drive their pins
            oe_reg <= OUT_OK[c] && (mode == `CCU_MODE_CMP1 ||
                mode == `CCU_MODE_CMP3 ||
                mode == `CCU_MODE_DBL);
            // Period ends at overflow; a match there opens a new one
            if (ovf) begin
                done_reg <= hit;
            end else if (hit) begin
                done_reg <= 1'b1;
            end
            case (mode)
                `CCU_MODE_CMP0: begin
                    if (hit) begin
                        irq_reg <= 1'b1;
                    end
                end
                `CCU_MODE_CMP1: begin
                    if (hit) begin
                        pin_reg <= ~pin_reg;
                        irq_reg <= 1'b1;
                    end
                end
                `CCU_MODE_CMP2: begin
                    if (hit && (ovf || !done_reg)) begin
                        irq_reg <= 1'b1;
                    end
                end
                `CCU_MODE_CMP3: begin
                    if (hit && (ovf || !done_reg)) begin
                        pin_reg <= 1'b1;
                        irq_reg <= 1'b1;
                    end else if (ovf) begin
                        pin_reg <= 1'b0;
                    end
                end
                `CCU_MODE_DBL: begin
                    if (dbl_hit) begin
                        pin_reg <= ~pin_reg;
                        irq_reg <= 1'b1;
                    end
                end
                default: begin
                    pin_reg <= pin_reg;
                end
            endcase
        end
    end

    assign ch_val[16 * c +: 16] = val_reg;
    assign ch_ctl[8 * c +: 8] = {pin_reg, done_reg, ctl_reg};
    assign O_CC_PIN[c] = pin_reg;
    assign O_CC_OE[c] = oe_reg;
    assign O_CC_IRQ[c] = irq_reg;
end
endgenerate

// ************************************************************
// Read multiplexer
// ************************************************************
// Unmapped words read as zero and are still acknowledged
always @* begin
    rd_next = 32'h0000_0000;
    if (bus_idx[7:2] == 6'h00) begin
        rd_next[5:0] = tmr_ctl[6 * bus_idx[1:0] +: 6];
    end else if (bus_idx[7:2] == 6'h01) begin
        rd_next[15:0] = tmr_val[16 * bus_idx[1:0] +: 16];
    end else if (bus_idx[7:2] == 6'h02) begin
        rd_next[15:0] = tmr_rld[16 * bus_idx[1:0] +: 16];
    end else if (bus_idx[7:5] == 3'h1) begin
        rd_next[7:0] = ch_ctl[8 * bus_idx[4:0] +: 8];
    end else if (bus_idx[7:5] == 3'h2) begin
        rd_next[15:0] = ch_val[16 * bus_idx[4:0] +: 16];
    end
end

endmodule // ccu_array

// ---- test/ccu_array_chk.sv ----
/* Port checker for the capture/compare array.
   Assumes binding onto ccu_array: one clock, async high reset. */
module ccu_array_chk #(
    parameter [31:0] OUT_OK = 32'hf0ff_ffff
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic [31:0] O_CC_PIN,
    input wire logic [31:0] O_CC_OE,
    input wire logic [31:0] O_CC_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************************
    // Bus and pin relations
    // ********************************************************
    wire logic req = I_WB_CYC & I_WB_STB; // Bus request present
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    a_ack_latency:
        assert property (req && !O_WB_ACK |=> O_WB_ACK)
        else $error("ack missing one cycle after request");
    a_ack_pulse:
        assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");
    a_ack_needs_req:
        assert property (!req |=> !O_WB_ACK)
        else $error("ack without request");
    a_dat_held:
        assert property (!req |=> $stable(O_WB_DAT))
        else $error("read data moved while bus idle");
    a_oe_masked:
        assert property ((O_CC_OE & ~OUT_OK) == 32'h0)
        else $error("input-only channel drives its pin");
    a_oe_by_write:
        assert property ($changed(O_CC_OE) |-> $past(req && I_WB_WE))
        else $error("output enable changed without a write");
    a_pin_needs_oe:
        assert property ($changed(O_CC_PIN[4])
            |-> O_CC_OE[4] || $past(O_CC_OE[4]))
        else $error("pin moved while not an output");
    a_reset_quiet:
        assert property ($fell(I_RST)
            |-> O_CC_IRQ == 32'h0 && O_CC_OE == 32'h0 && !O_WB_ACK)
        else $error("outputs not cleared by reset");
    // Main scenarios reached
    c_capture: cover property (O_CC_IRQ[0]);
    c_mode3_set: cover property (O_CC_PIN[5]);
    c_write: cover property (req && I_WB_WE && O_WB_ACK);
endmodule // ccu_array_chk

bind ccu_array ccu_array_chk #(.OUT_OK(OUT_OK)) i_ccu_array_chk (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .O_WB_DAT(O_WB_DAT),
    .O_WB_ACK(O_WB_ACK), .O_CC_PIN(O_CC_PIN), .O_CC_OE(O_CC_OE),
    .O_CC_IRQ(O_CC_IRQ));

// ---- test/ccu_pins.sv ----
/* Model of the channel pins and count lines around the array.
   Assumes its tasks are called from processes on the same clock. */
module ccu_pins (
    input wire logic i_clk,
    output logic [31:0] o_pin,
    output logic [1:0] o_ext,
    output logic o_gt6
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet lines at start; timer six idle until pulsed
    initial begin
        o_pin = 32'h0;
        o_ext = 2'h0;
        o_gt6 = 1'b0;
    end
    // Level held well past the two-stage synchroniser
    task set_pin(input int ch, input logic lvl);
        @(posedge i_clk);
        o_pin[ch] <= lvl;
        repeat (8) @(posedge i_clk);
    endtask
    // One signal feeds both count lines, so both timers see it
    task pulse_ext();
        @(posedge i_clk);
        o_ext <= 2'h3;
        repeat (5) @(posedge i_clk);
        o_ext <= 2'h0;
        repeat (5) @(posedge i_clk);
    endtask
    // One-cycle overflow pulse of timer six, same clock
    task pulse_gt6();
        @(posedge i_clk);
        o_gt6 <= 1'b1;
        @(posedge i_clk);
        o_gt6 <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // ccu_pins

// ---- test/ccu_array_tb.sv ----
/* Self-checking bench for the capture/compare array.
   Assumes the pin model and the bound checker are compiled first. */
module ccu_array_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst = 1'b1, cyc, stb, we, ack, gt6;
    logic [9:0] adr;
    logic [31:0] wdat, rdat, got, pin_out, oe, irq, pin_in;
    logic [3:0] sel;
    logic [1:0] ext;
    int miscompares = 0;
    int compares = 0;
    // Pulses seen per channel; four-state so an unknown shows up
    logic [31:0] irq_cnt [32] = '{default: 32'h0};
    int chs [6] = '{3, 4, 5, 27, 6, 7}; // Compare channels under test
    logic [31:0] mds [6] = '{32'h4, 32'h5, 32'h7, 32'h5, 32'h6, 32'h2};

    ccu_array i_ccu_array (.I_MCLK(clk), .I_RST(rst), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat),
        .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_GT6_OVF(gt6),
        .I_EXT_CNT(ext), .I_CC_PIN(pin_in), .O_CC_PIN(pin_out),
        .O_CC_OE(oe), .O_CC_IRQ(irq));
    ccu_pins i_ccu_pins (.i_clk(clk), .o_pin(pin_in), .o_ext(ext),
        .o_gt6(gt6));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count interrupt pulses, one cycle each
    always @(posedge clk) begin
        for (int i = 0; i < 32; i++) irq_cnt[i] <= irq_cnt[i] + irq[i];
    end
    // ********************************************************
    // Bus cycle, compare and closing tasks
    // ********************************************************
    task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Hold the request until ack is seen high at a rising edge
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task chk(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rd(input string what, input logic [9:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(what, got, e);
    endtask
    task complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    // ********************************************************
    // Tests
    // ********************************************************
    initial begin
        {cyc, stb, we, adr, wdat, sel} = {3'h0, 10'h0, 32'h0, 4'h3};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wb(1'b1, 10'h020, 32'h00a5);
        rd("reload", 10'h020, 32'h0000_00a5);
        rd("unmapped", 10'h3fc, 32'h0);
        $display("test registers done");
        // Stopped timer, so every capture sees the same count
        wb(1'b1, 10'h010, 32'h1234);
        for (int c = 0; c < 3; c++) wb(1'b1, 10'(128 + 4 * c), 32'(17 + 16 * c));
        for (int c = 0; c < 3; c++) i_ccu_pins.set_pin(c, 1'b1);
        for (int c = 0; c < 3; c++) i_ccu_pins.set_pin(c, 1'b0);
        chk("rise irq", irq_cnt[0], 32'h1);
        chk("fall irq", irq_cnt[1], 32'h1);
        chk("both irq", irq_cnt[2], 32'h2);
        rd("captured", 10'h100, 32'h0000_1234);
        $display("test capture done");
        // Both first timers on the shared count line, match at 5
        wb(1'b1, 10'h010, 32'h3);
        wb(1'b1, 10'h018, 32'h3);
        // Double mode channel 7 matches at 4 itself and at 5 via 15
        wb(1'b1, 10'h13c, 32'h5);
        for (int k = 0; k < 6; k++) begin
            wb(1'b1, 10'(256 + 4 * chs[k]), (chs[k] == 7) ? 32'h4 : 32'h5);
            wb(1'b1, 10'(128 + 4 * chs[k]), mds[k]);
        end
        wb(1'b1, 10'h000, 32'h5);
        wb(1'b1, 10'h008, 32'h5);
        repeat (2) i_ccu_pins.pulse_ext();
        chk("mode0 irq", irq_cnt[3], 32'h1);
        chk("mode0 oe", 32'(oe[3]), 32'h0);
        chk("mode1 pin", 32'(pin_out[4]), 32'h1);
        chk("mode1 irq", irq_cnt[4], 32'h1);
        chk("mode1 oe", 32'(oe[4]), 32'h1);
        chk("mode3 pin", 32'(pin_out[5]), 32'h1);
        chk("input only oe", 32'(oe[27]), 32'h0);
        rd("ext count", 10'h010, 32'h5);
        rd("lockstep", 10'h018, 32'h5);
        chk("mode2 irq", irq_cnt[6], 32'h1);
        chk("double irq", irq_cnt[7], 32'h2);
        chk("double pin", 32'(pin_out[7]), 32'h0);
        // Rewind and match 5 again inside the same period
        wb(1'b1, 10'h010, 32'h4);
        i_ccu_pins.pulse_ext();
        chk("mode0 again", irq_cnt[3], 32'h2);
        chk("mode1 again", 32'(pin_out[4]), 32'h0);
        chk("mode2 once", irq_cnt[6], 32'h1);
        chk("mode3 once", irq_cnt[5], 32'h1);
        chk("double again", 32'(pin_out[7]), 32'h1);
        // Overflow reloads and clears the mode 3 pin
        wb(1'b1, 10'h010, 32'hffff);
        i_ccu_pins.pulse_ext();
        rd("reloaded", 10'h010, 32'h00a5);
        chk("mode3 clear", 32'(pin_out[5]), 32'h0);
        chk("mode1 hold", 32'(pin_out[4]), 32'h0);
        $display("test compare done");
        // Timer b of unit one counts timer six overflows
        wb(1'b1, 10'h004, 32'h3);
        wb(1'b1, 10'h120, 32'h1);
        wb(1'b1, 10'h0a0, 32'hc);
        i_ccu_pins.pulse_gt6();
        chk("timer b match", irq_cnt[8], 32'h1);
        rd("gt6 count", 10'h014, 32'h1);
        // Divide by 16 over 160 clocks between start and stop writes
        wb(1'b1, 10'h00c, 32'h9);
        repeat (157) @(posedge clk);
        wb(1'b1, 10'h00c, 32'h8);
        rd("prescaled", 10'h01c, 32'ha);
        $display("test sources done");
        complete_run();
    end
endmodule // ccu_array_tb
